// file: verilog/hpc_pkg.sv
// package: register map, field layout and decode types for the pin config bank
package hpc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] OFS_PIN_SETUP = 8'ha4;
    localparam logic [7:0] OFS_DEV_ONE = 8'ha6;
    localparam logic [7:0] OFS_DEV_TWO = 8'ha8;
    localparam logic [7:0] OFS_PERI_ONE = 8'haa;
    localparam logic [7:0] OFS_GATE_ONE = 8'hac;
    localparam logic [7:0] OFS_GATE_TWO = 8'hae;
    localparam logic [7:0] OFS_STEP = 8'h02;
    localparam int unsigned NUM_REGS = 6;
    localparam logic [31:0] RST_VALUE = 32'h00000000;
    // writable bits of the pin setup word: 31, 6 and 4 are reserved
    localparam logic [31:0] PIN_WMASK = 32'h7fffffaf;
    localparam int unsigned POS_FWC = 28;
    localparam int unsigned POS_DCF = 27;
    localparam int unsigned POS_LEAD = 22;
    localparam int unsigned POS_PWR = 11;
    localparam int unsigned POS_STOP = 9;
    localparam int unsigned POS_FAULT = 7;
    localparam int unsigned POS_BSTYLE = 5;
    localparam int unsigned POS_BSRC = 2;
    localparam int unsigned POS_REF = 0;
    localparam logic [4:0] LEAD_KNEE = 5'h0f;
    localparam logic [10:0] PWR_KNEE = 11'h400;

    typedef enum logic [3:0] {
        HPC_REF_ANALOG = 4'h1,
        HPC_REF_DUTY = 4'h2,
        HPC_REF_REGISTER = 4'h4,
        HPC_REF_FREQ = 4'h8
    } hpc_ref_src_t;

    typedef enum logic [2:0] {
        HPC_BRK_PIN = 3'h1,
        HPC_BRK_FORCE = 3'h2,
        HPC_BRK_NONE = 3'h4
    } hpc_brk_src_t;

    typedef enum logic [2:0] {
        HPC_TACH_RUN = 3'h1,
        HPC_TACH_HIZ = 3'h2,
        HPC_TACH_LOW = 3'h4
    } hpc_tach_mode_t;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } hpc_bus_req_t;

    // decoded pin setup, as presented to motor control
    typedef struct packed {
        logic [6:0] field_weaken_current_ceiling;
        logic fw_circular_only;
        logic dc_link_filter_bypass;
        logic [5:0] lead_angle_deg;
        logic [11:0] max_power_watt;
        logic [1:0] tach_out_stopped_behaviour;
        logic [1:0] tach_out_fault_behaviour;
        logic brake_style;
        hpc_brk_src_t brake_src;
        hpc_ref_src_t ref_src;
    } hpc_decoded_t;
endpackage

// file: verilog/hpc_reg_store.sv
// register storage: six words, one write port, registered read data
`timescale 1ns/10ps
`default_nettype none
module hpc_reg_store (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [2:0] wr_idx_i,
    input wire logic [31:0] wr_data_i,
    input wire logic [31:0] wr_mask_i,
    // read port
    input wire logic rd_en_i,
    input wire logic [2:0] rd_idx_i,
    output logic [31:0] rd_data_o,
    // pin setup word, always visible
    output logic [31:0] pin_word_o
);
    logic [31:0] mem [hpc_pkg::NUM_REGS];
    logic [31:0] next_mem [hpc_pkg::NUM_REGS];
    logic [31:0] next_rd_data;

    always_comb begin
        for (int i = 0; i < hpc_pkg::NUM_REGS; i++) begin
            next_mem[i] = mem[i];
        end
        if (wr_en_i) begin
            next_mem[wr_idx_i] = (mem[wr_idx_i] & ~wr_mask_i)
                               | (wr_data_i & wr_mask_i);
        end
        next_rd_data = rd_en_i ? mem[rd_idx_i] : 32'h00000000;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < hpc_pkg::NUM_REGS; i++) begin
                mem[i] <= hpc_pkg::RST_VALUE; // RQ3
            end
            rd_data_o <= 32'h00000000;
        end else begin
            for (int i = 0; i < hpc_pkg::NUM_REGS; i++) begin
                mem[i] <= next_mem[i];
            end
            rd_data_o <= next_rd_data;
        end
    end

    assign pin_word_o = mem[0];
endmodule
`default_nettype wire

// file: verilog/hpc_field_decode.sv
// decodes the pin setup word into its field values
`timescale 1ns/10ps
`default_nettype none
module hpc_field_decode (
    // raw word
    input wire logic [31:0] word_i,
    // decoded fields
    output var hpc_pkg::hpc_decoded_t dec_o
);
    // piecewise scale: one-to-one up to knee, then steps of two
    function automatic logic [11:0] knee_scale(input logic [10:0] code,
                                               input logic [10:0] knee);
        logic [11:0] c;
        c = {1'b0, code};
        if (code <= knee) begin
            knee_scale = c;
        end else begin
            knee_scale = 12'((c - {1'b0, knee}) << 1) + {1'b0, knee};
        end
    endfunction

    logic [2:0] fwc;
    logic [4:0] lead;
    logic [10:0] pwr;
    logic [1:0] bsrc;
    logic [1:0] refs;
    logic [11:0] lead_full;

    assign fwc = word_i[hpc_pkg::POS_FWC +: 3];
    assign lead = word_i[hpc_pkg::POS_LEAD +: 5];
    assign pwr = word_i[hpc_pkg::POS_PWR +: 11];
    assign bsrc = word_i[hpc_pkg::POS_BSRC +: 2];
    assign refs = word_i[hpc_pkg::POS_REF +: 2];
    assign lead_full = knee_scale({6'h00, lead},
                                  {6'h00, hpc_pkg::LEAD_KNEE});

    always_comb begin
        // code 0 means circular limit only; 1..7 is 80 down to 20 percent
        dec_o.fw_circular_only = (fwc == 3'h0); // RQ4
        dec_o.field_weaken_current_ceiling =
            (fwc == 3'h0) ? 7'h00 : 7'(7'd90 - 7'd10 * {4'h0, fwc}); // RQ4
        dec_o.dc_link_filter_bypass = word_i[hpc_pkg::POS_DCF]; // RQ5
        dec_o.lead_angle_deg = lead_full[5:0]; // RQ6
        // knee is inclusive, so code 1024 still maps to 1024
        dec_o.max_power_watt = knee_scale(pwr, hpc_pkg::PWR_KNEE); // RQ7
        dec_o.tach_out_stopped_behaviour =
            word_i[hpc_pkg::POS_STOP +: 2]; // RQ8
        dec_o.tach_out_fault_behaviour =
            word_i[hpc_pkg::POS_FAULT +: 2]; // RQ9
        dec_o.brake_style = word_i[hpc_pkg::POS_BSTYLE]; // RQ11
        unique case (bsrc)
            2'h1: dec_o.brake_src = hpc_pkg::HPC_BRK_FORCE; // RQ12
            2'h2: dec_o.brake_src = hpc_pkg::HPC_BRK_NONE; // RQ12
            default: dec_o.brake_src = hpc_pkg::HPC_BRK_PIN; // RQ12
        endcase
        unique case (refs)
            2'h0: dec_o.ref_src = hpc_pkg::HPC_REF_ANALOG; // RQ13
            2'h1: dec_o.ref_src = hpc_pkg::HPC_REF_DUTY; // RQ13
            2'h2: dec_o.ref_src = hpc_pkg::HPC_REF_REGISTER; // RQ13
            2'h3: dec_o.ref_src = hpc_pkg::HPC_REF_FREQ; // RQ13
        endcase
    end
endmodule
`default_nettype wire

// file: verilog/hpc_pin_setup_bank.sv
// hardware pin configuration bank: register slave, decode and pin control
// Contract
// (RQ1) The six configuration words sit at even offsets a4h to aeh.
// (RQ2) Software leaves other offsets in the region untouched.
// (RQ3) The pin setup word answers at a4h and resets to all zeros.
// (RQ4) Bits 30..28 set the field-weakening ceiling, 0 circular, 1..7 80..20%.
// (RQ5) Bit 27 set to one bypasses the dc-link filter.
// (RQ6) Bits 26..22 give the lead angle, doubling steps above 15.
// (RQ7) Bits 21..11 give max power, doubling steps above 1024.
// (RQ8) Bits 10..9 steer the tach output while stopped.
// (RQ9) Bits 8..7 steer the tach output during a fault.
// (RQ10) Fault code 3 with coast option set keeps tach toggling above bemf.
// (RQ11) Bit 5 picks the braking style, zero being low-side braking.
// (RQ12) Bits 3..2 pick the brake source: pin, forced, or none.
// (RQ13) Bits 1..0 pick the speed reference source.
// (RQ14) Reserved bits 31, 6 and 4 read zero and ignore writes.
// (RQ15) Words are 32 bits and decoded fields follow a write at once.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module hpc_pin_setup_bank (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // motor state from control core
    input wire logic motor_stopped_i,
    input wire logic fault_active_i,
    input wire logic tach_pulse_i,
    input wire logic tach_out_coast_option_i,
    input wire logic bemf_above_threshold_i,
    input wire logic brake_pin_i,
    // decoded configuration
    output var hpc_pkg::hpc_decoded_t cfg_o,
    // brake request to gate driver
    output logic brake_low_side_o,
    // speed feedback open-drain pin
    output logic speed_feedback_output_o,
    output logic speed_feedback_output_oe_o
);
    hpc_pkg::hpc_bus_req_t req;
    logic hit;
    logic [3:0] slot;
    logic [2:0] idx;
    logic [31:0] wmask;
    logic [31:0] pin_word;
    logic [31:0] store_rdata;
    logic rd_hit_q;
    logic next_rd_hit_q;
    hpc_pkg::hpc_decoded_t dec;
    hpc_pkg::hpc_tach_mode_t tach_mode;
    hpc_pkg::hpc_tach_mode_t next_tach_mode;
    logic tach_q;
    logic next_tach_q;

    // offset to index: even offsets only, a4h..aeh
    function automatic logic [3:0] map_offset(input logic [7:0] a);
        logic [7:0] d;
        d = a - hpc_pkg::OFS_PIN_SETUP;
        if (a >= hpc_pkg::OFS_PIN_SETUP && a <= hpc_pkg::OFS_GATE_TWO
            && a[0] == 1'b0) begin
            map_offset = {1'b1, d[3:1]};
        end else begin
            map_offset = 4'h0;
        end
    endfunction

    assign req = {addr_i, wdata_i, wr_i, rd_i};
    assign slot = map_offset(req.addr); // RQ1
    assign hit = slot[3];
    assign idx = slot[2:0];
    // reserved bits of the pin word never store, the rest store whole
    assign wmask = (idx == 3'h0) ? hpc_pkg::PIN_WMASK : 32'hffffffff; // RQ14

    hpc_reg_store u_store (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .wr_en_i(req.wr && hit),
        .wr_idx_i(idx),
        .wr_data_i(req.wdata),
        .wr_mask_i(wmask),
        .rd_en_i(req.rd && hit),
        .rd_idx_i(idx),
        .rd_data_o(store_rdata),
        .pin_word_o(pin_word)
    );

    hpc_field_decode u_dec (
        .word_i(pin_word),
        .dec_o(dec)
    );

    // unmapped reads return zero the cycle after the strobe
    always_comb begin
        next_rd_hit_q = req.rd && hit;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rd_hit_q <= 1'b0;
        end else begin
            rd_hit_q <= next_rd_hit_q;
        end
    end

    assign rdata_o = rd_hit_q ? store_rdata : 32'h00000000; // RQ15
    // decode is combinational off the stored word: live after a write
    assign cfg_o = dec; // RQ15

    // brake: forced source uses style bit; style one is reserved
    always_comb begin
        unique case (dec.brake_src)
            hpc_pkg::HPC_BRK_FORCE: brake_low_side_o = ~dec.brake_style; // RQ12
            hpc_pkg::HPC_BRK_NONE: brake_low_side_o = 1'b0; // RQ12
            default: brake_low_side_o = brake_pin_i; // RQ12
        endcase
    end

    // tach pin mode: fault has priority over stopped
    always_comb begin
        next_tach_mode = hpc_pkg::HPC_TACH_RUN;
        if (fault_active_i) begin
            unique case (dec.tach_out_fault_behaviour)
                2'h2: next_tach_mode = hpc_pkg::HPC_TACH_LOW; // RQ9
                2'h3: next_tach_mode = (tach_out_coast_option_i
                                        && bemf_above_threshold_i)
                                       ? hpc_pkg::HPC_TACH_RUN
                                       : hpc_pkg::HPC_TACH_HIZ; // RQ10
                default: next_tach_mode = hpc_pkg::HPC_TACH_HIZ; // RQ9
            endcase
        end else if (motor_stopped_i) begin
            unique case (dec.tach_out_stopped_behaviour)
                2'h0: next_tach_mode = hpc_pkg::HPC_TACH_RUN; // RQ8
                2'h2: next_tach_mode = hpc_pkg::HPC_TACH_LOW; // RQ8
                default: next_tach_mode = hpc_pkg::HPC_TACH_HIZ; // RQ8
            endcase
        end
        // open drain: only a low level is ever driven
        next_tach_q = (next_tach_mode == hpc_pkg::HPC_TACH_LOW)
                    || (next_tach_mode == hpc_pkg::HPC_TACH_RUN
                        && !tach_pulse_i);
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            tach_mode <= hpc_pkg::HPC_TACH_HIZ;
            tach_q <= 1'b0;
        end else begin
            tach_mode <= next_tach_mode;
            tach_q <= next_tach_q;
        end
    end

    assign speed_feedback_output_o = 1'b0;
    assign speed_feedback_output_oe_o = tach_q;

    // checks
    property p_rst_zero;
        @(posedge clk_sys_i) disable iff (reset_i)
        $fell(reset_i) |-> pin_word == hpc_pkg::RST_VALUE;
    endproperty
    a_rst_zero: assert property (p_rst_zero) // RQ3
        else $error("pin word not zero after reset");

    property p_rsvd_zero;
        @(posedge clk_sys_i) disable iff (reset_i)
        (pin_word & ~hpc_pkg::PIN_WMASK) == 32'h00000000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) // RQ14
        else $error("reserved pin word bit set");

    property p_write_live;
        @(posedge clk_sys_i) disable iff (reset_i)
        (wr_i && addr_i == hpc_pkg::OFS_PIN_SETUP) |=>
        pin_word == ($past(wdata_i) & hpc_pkg::PIN_WMASK);
    endproperty
    a_write_live: assert property (p_write_live) // RQ15
        else $error("pin word not updated by write");

    sequence s_read_a4;
        rd_i && addr_i == hpc_pkg::OFS_PIN_SETUP;
    endsequence
    property p_read_back;
        @(posedge clk_sys_i) disable iff (reset_i)
        s_read_a4 |=> rdata_o == $past(pin_word);
    endproperty
    a_read_back: assert property (p_read_back) // RQ1
        else $error("pin word readback mismatch");

    property p_odd_zero;
        @(posedge clk_sys_i) disable iff (reset_i)
        (rd_i && addr_i[0]) |=> rdata_o == 32'h00000000;
    endproperty
    a_odd_zero: assert property (p_odd_zero) // RQ1
        else $error("odd offset answered");

    property p_fault_low;
        @(posedge clk_sys_i) disable iff (reset_i)
        (fault_active_i && dec.tach_out_fault_behaviour == 2'h2)
        |=> speed_feedback_output_oe_o;
    endproperty
    a_fault_low: assert property (p_fault_low) // RQ9
        else $error("tach not low in fault");

    property p_stop_hiz;
        @(posedge clk_sys_i) disable iff (reset_i)
        (!fault_active_i && motor_stopped_i
         && dec.tach_out_stopped_behaviour[0]) |=> !speed_feedback_output_oe_o;
    endproperty
    a_stop_hiz: assert property (p_stop_hiz) // RQ8
        else $error("tach driven while stopped hiz");

    property p_coast;
        @(posedge clk_sys_i) disable iff (reset_i)
        (fault_active_i && dec.tach_out_fault_behaviour == 2'h3
         && tach_out_coast_option_i && bemf_above_threshold_i)
        |=> speed_feedback_output_oe_o == !$past(tach_pulse_i);
    endproperty
    a_coast: assert property (p_coast) // RQ10
        else $error("tach not following pulse while coasting");

    property p_brake_none;
        @(posedge clk_sys_i) disable iff (reset_i)
        pin_word[3:2] == 2'h2 |-> !brake_low_side_o;
    endproperty
    a_brake_none: assert property (p_brake_none) // RQ12
        else $error("brake asserted with source none");

    property p_fwc;
        @(posedge clk_sys_i) disable iff (reset_i)
        pin_word[30:28] == 3'h7 |-> dec.field_weaken_current_ceiling == 7'd20;
    endproperty
    a_fwc: assert property (p_fwc) // RQ4
        else $error("ceiling code 7 not 20 percent");

    property p_lead;
        @(posedge clk_sys_i) disable iff (reset_i)
        pin_word[26:22] == 5'h1f |-> dec.lead_angle_deg == 6'd47;
    endproperty
    a_lead: assert property (p_lead) // RQ6
        else $error("lead angle code 31 wrong");

    property p_lead_knee;
        @(posedge clk_sys_i) disable iff (reset_i)
        pin_word[26:22] == 5'h10 |-> dec.lead_angle_deg == 6'h11;
    endproperty
    a_lead_knee: assert property (p_lead_knee) // RQ6
        else $error("lead angle code 16 wrong");

    property p_pwr_knee;
        @(posedge clk_sys_i) disable iff (reset_i)
        pin_word[21:11] == 11'h400 |-> dec.max_power_watt == 12'h400;
    endproperty
    a_pwr_knee: assert property (p_pwr_knee) // RQ7
        else $error("power code 1024 wrong");

    property p_pwr_top;
        @(posedge clk_sys_i) disable iff (reset_i)
        pin_word[21:11] == 11'h7ff |-> dec.max_power_watt == 12'hbfe;
    endproperty
    a_pwr_top: assert property (p_pwr_top) // RQ7
        else $error("power code 2047 wrong");

    property p_fwc_zero;
        @(posedge clk_sys_i) disable iff (reset_i)
        pin_word[30:28] == 3'h0 |-> dec.fw_circular_only
            && dec.field_weaken_current_ceiling == 7'h00;
    endproperty
    a_fwc_zero: assert property (p_fwc_zero) // RQ4
        else $error("ceiling code 0 not circular only");

    property p_mode_hiz;
        @(posedge clk_sys_i) disable iff (reset_i)
        tach_mode == hpc_pkg::HPC_TACH_HIZ |-> !speed_feedback_output_oe_o;
    endproperty
    a_mode_hiz: assert property (p_mode_hiz) // RQ8
        else $error("tach driven in hiz mode");

    property p_stop_low;
        @(posedge clk_sys_i) disable iff (reset_i)
        (!fault_active_i && motor_stopped_i
         && dec.tach_out_stopped_behaviour == 2'h2)
        |=> speed_feedback_output_oe_o;
    endproperty
    a_stop_low: assert property (p_stop_low) // RQ8
        else $error("tach not low while stopped");

    property p_stop_run;
        @(posedge clk_sys_i) disable iff (reset_i)
        (!fault_active_i && motor_stopped_i
         && dec.tach_out_stopped_behaviour == 2'h0)
        |=> speed_feedback_output_oe_o == !$past(tach_pulse_i);
    endproperty
    a_stop_run: assert property (p_stop_run) // RQ8
        else $error("tach not running while stopped");

    property p_fault_hiz;
        @(posedge clk_sys_i) disable iff (reset_i)
        (fault_active_i && !dec.tach_out_fault_behaviour[1])
        |=> !speed_feedback_output_oe_o;
    endproperty
    a_fault_hiz: assert property (p_fault_hiz) // RQ9
        else $error("tach driven in fault hiz");

    property p_coast_off;
        @(posedge clk_sys_i) disable iff (reset_i)
        (fault_active_i && dec.tach_out_fault_behaviour == 2'h3
         && !(tach_out_coast_option_i && bemf_above_threshold_i))
        |=> !speed_feedback_output_oe_o;
    endproperty
    a_coast_off: assert property (p_coast_off) // RQ10
        else $error("tach driven after coasting ends");

    property p_brake_style;
        @(posedge clk_sys_i) disable iff (reset_i)
        (pin_word[3:2] == 2'h1 && !pin_word[5]) |-> brake_low_side_o;
    endproperty
    a_brake_style: assert property (p_brake_style) // RQ11
        else $error("forced low side brake missing");

    property p_brake_pin;
        @(posedge clk_sys_i) disable iff (reset_i)
        pin_word[3] == pin_word[2] |-> brake_low_side_o == brake_pin_i;
    endproperty
    a_brake_pin: assert property (p_brake_pin) // RQ12
        else $error("brake not following pin");

    property p_ref_reg;
        @(posedge clk_sys_i) disable iff (reset_i)
        pin_word[1:0] == 2'h2 |-> dec.ref_src == hpc_pkg::HPC_REF_REGISTER;
    endproperty
    a_ref_reg: assert property (p_ref_reg) // RQ13
        else $error("reference source code 2 wrong");

    property p_idle_zero;
        @(posedge clk_sys_i) disable iff (reset_i)
        !rd_i |=> rdata_o == 32'h00000000;
    endproperty
    a_idle_zero: assert property (p_idle_zero) // RQ1
        else $error("read data without read strobe");

    property p_other_keep;
        @(posedge clk_sys_i) disable iff (reset_i)
        (wr_i && addr_i != hpc_pkg::OFS_PIN_SETUP) |=> $stable(pin_word);
    endproperty
    a_other_keep: assert property (p_other_keep) // RQ1
        else $error("pin word changed by other write");
endmodule
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the pin configuration bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h00000000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic motor_stopped_i = 1'b0;
    logic fault_active_i = 1'b0;
    logic tach_pulse_i = 1'b0;
    logic tach_out_coast_option_i = 1'b0;
    logic bemf_above_threshold_i = 1'b0;
    logic brake_pin_i = 1'b0;
    hpc_pkg::hpc_decoded_t cfg_o;
    logic brake_low_side_o;
    logic speed_feedback_output_o;
    logic speed_feedback_output_oe_o;
    int num_errors = 0;
    int compares = 0;
    logic [31:0] seed = 32'h00000024;
    logic [31:0] rv;
    logic [31:0] shadow [6];
    logic [31:0] corner [7] = '{32'hffffffff, 32'h03c00000, 32'h04000000,
        32'h07c00000, 32'h001ff800, 32'h00200000, 32'h003ff800};

    hpc_pin_setup_bank i_hpc_pin_setup_bank (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .motor_stopped_i(motor_stopped_i),
        .fault_active_i(fault_active_i),
        .tach_pulse_i(tach_pulse_i),
        .tach_out_coast_option_i(tach_out_coast_option_i),
        .bemf_above_threshold_i(bemf_above_threshold_i),
        .brake_pin_i(brake_pin_i),
        .cfg_o(cfg_o),
        .brake_low_side_o(brake_low_side_o),
        .speed_feedback_output_o(speed_feedback_output_o),
        .speed_feedback_output_oe_o(speed_feedback_output_oe_o)
    );

    always #4 clk_sys_i = ~clk_sys_i;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    function automatic hpc_pkg::hpc_decoded_t exp_dec(input logic [31:0] w);
        hpc_pkg::hpc_decoded_t d;
        logic [2:0] f;
        logic [4:0] la;
        logic [10:0] p;
        f = w[30:28];
        la = w[26:22];
        p = w[21:11];
        d = '0;
        d.field_weaken_current_ceiling = (f == 3'h0) ? 7'h00 : 7'(90 - 10 * f);
        d.fw_circular_only = (f == 3'h0);
        d.dc_link_filter_bypass = w[27];
        d.lead_angle_deg = (la <= 5'h0f) ? {1'b0, la} : 6'(2 * (la - 15) + 15);
        d.max_power_watt = (p < 11'h400) ? {1'b0, p} : 12'(2 * (p - 1024) + 1024);
        d.tach_out_stopped_behaviour = w[10:9];
        d.tach_out_fault_behaviour = w[8:7];
        d.brake_style = w[5];
        d.brake_src = (w[3:2] == 2'h1) ? hpc_pkg::HPC_BRK_FORCE :
            (w[3:2] == 2'h2) ? hpc_pkg::HPC_BRK_NONE : hpc_pkg::HPC_BRK_PIN;
        d.ref_src = hpc_pkg::hpc_ref_src_t'(4'(4'h1 << w[1:0]));
        return d;
    endfunction

    // open drain: enable high pulls the pin low
    function automatic logic exp_oe(input logic [31:0] w, input logic [4:0] c);
        if (c[1]) begin
            if (w[8:7] == 2'h3) begin
                return c[3] && c[4] && !c[2];
            end
            return w[8:7] == 2'h2;
        end
        if (c[0]) begin
            if (w[10:9] == 2'h0) begin
                return !c[2];
            end
            return w[10:9] == 2'h2;
        end
        return !c[2];
    endfunction

    function automatic logic exp_brk(input logic [31:0] w, input logic bp);
        case (w[3:2])
            2'h1: return !w[5];
            2'h2: return 1'b0;
            default: return bp;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [63:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic check_all();
        logic [31:0] d;
        for (int i = 0; i < 6; i++) begin
            rd_reg(8'(8'ha4 + 2 * i), d);
            chk("word", d, shadow[i]);
        end
    endtask

    // a pin word is written, then its decode, brake and tach pin are checked
    task automatic pin_word(input logic [31:0] w);
        logic [31:0] m;
        logic [31:0] d;
        m = w & 32'h7fffffaf;
        wr_reg(8'ha4, w);
        chk("cfg", cfg_o, exp_dec(m));
        rd_reg(8'ha4, d);
        chk("pin word", d, m);
        for (int b = 0; b < 2; b++) begin
            @(posedge clk_sys_i);
            brake_pin_i <= b[0];
            #1;
            chk("brake", brake_low_side_o, exp_brk(m, b[0]));
        end
        for (int c = 0; c < 32; c++) begin
            @(posedge clk_sys_i);
            {bemf_above_threshold_i, tach_out_coast_option_i, tach_pulse_i,
                fault_active_i, motor_stopped_i} <= 5'(c);
            @(posedge clk_sys_i);
            #1;
            chk("tach oe", speed_feedback_output_oe_o, exp_oe(m, 5'(c)));
            chk("tach out", speed_feedback_output_o, 1'b0);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        num_errors++;
        close_out();
    end

    initial begin
        logic [31:0] d;
        for (int i = 0; i < 6; i++) begin
            shadow[i] = 32'h00000000;
        end
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        check_all();
        chk("cfg reset", cfg_o, exp_dec(32'h00000000));
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            shadow[i] = (i == 0) ? seed & 32'h7fffffaf : seed;
            wr_reg(8'(8'ha4 + 2 * i), seed);
        end
        check_all();
        // reserved offsets are only read by software, never written
        foreach (corner[k]) begin
            seed = xs(seed);
            rv = {seed[7:1], 1'b1};
            if (k == 0) begin
                rv = 8'hb0;
            end
            rd_reg(rv[7:0], d);
            chk("unmapped", d, 32'h00000000);
        end
        check_all();
        $display("test map done");
        foreach (corner[k]) begin
            pin_word(corner[k]);
        end
        for (int i = 0; i < 8; i++) begin
            rv = 32'(i) & 32'h3;
            pin_word((32'(i) << 28) | (rv << 9) | (rv << 7) | (rv << 2) | rv);
        end
        for (int i = 0; i < 20; i++) begin
            seed = xs(seed);
            pin_word(seed);
        end
        $display("test decode done");
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            shadow[i] = 32'h00000000;
        end
        check_all();
        $display("test second reset done");
        close_out();
    end
endmodule
`default_nettype wire
